// ==== ldp_map.svh ====
// Constants for the LED diagnostic and protection controller.
// Assumes inclusion by the package and the design files.
`ifndef LDP_MAP_SVH
`define LDP_MAP_SVH
`define LDP_CHANNELS 16
`define LDP_GS_WIDTH 16
`define LDP_GROUPS 4
`define LDP_GROUP_DELAY 4
`define LDP_LAT_CODE0 16'h0002
`define LDP_LAT_CODE1 16'h0021
`define LDP_LAT_CODE2 16'h0041
`define LDP_LAT_CODE3 16'h0081
`define LDP_PS_OFF 2'h0
`define LDP_PS_EXIT 2'h1
`define LDP_PS_DEEP 2'h2
`define LDP_PS_ALT 2'h3
`endif

// ==== ldp_pkg.sv ====
// Types for the LED diagnostic and protection controller.
// Assumes ldp_map.svh is on the include path.
package ldp_pkg;
`include "ldp_map.svh"
   typedef struct packed {
      logic ref_short;
      logic warn_temp;
      logic shut_temp;
   } ldp_sense_t;
   typedef struct packed {
      logic thermal_error_flag;
      logic thermal_warning_flag;
      logic ref_short_flag;
   } ldp_status_t;
   typedef enum logic [1:0] {
      LDP_RUN,
      LDP_SAVE,
      LDP_WAKE
   } ldp_ps_state_t;
endpackage

// ==== ldp_stagger.sv ====
// Group stagger for the sink outputs: each group's enables pass a delay line.
// Assumes enables come from logic on the same clock.
`timescale 1ns/1ps
module ldp_stagger import ldp_pkg::*; #(
   parameter int CH = 16,
   parameter int STEP = 4
) (
   input wire logic sys_clk_i, // System clock
   input wire logic sys_rst_i, // Synchronous reset
   input wire logic [CH-1:0] en_i, // Undelayed output enables
   output logic [CH-1:0] en_o // Staggered output enables
);
   localparam int DEPTH = 3 * STEP + 1;
   logic [CH-1:0] line_q [DEPTH];

   // Group index of a channel: pairs mirror about 3.5 within each half of eight
   function automatic int grp(input int ch);
      int m;
      m = ch % 8;
      grp = (m < 4) ? m : 7 - m;
   endfunction

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         for (int k = 0; k < DEPTH; k++) begin
            line_q[k] <= '0;
         end
      end else begin
         line_q[0] <= en_i;
         for (int k = 1; k < DEPTH; k++) begin
            line_q[k] <= line_q[k-1];
         end
      end
   end

   always_comb begin
      for (int c = 0; c < CH; c++) begin
         en_o[c] = line_q[grp(c) * STEP][c];
      end
   end
endmodule

// ==== ldp_ctrl.sv ====
// Diagnostic and protection control for a 16-channel sink driver.
// Assumes grayscale clock, serial clock and latch strobe arrive as pins sampled by sys_clk_i,
// comparators are asynchronous levels, and control fields are held stable by the host logic.
`timescale 1ns/1ps
module ldp_ctrl import ldp_pkg::*; #(
   parameter int CH = `LDP_CHANNELS,
   parameter int GSW = `LDP_GS_WIDTH,
   parameter int STEP = `LDP_GROUP_DELAY
) (
   input wire logic sys_clk_i, // System clock 100 MHz
   input wire logic sys_rst_i, // Synchronous reset, high
   input wire logic grayscale_clock_i, // Grayscale clock pin
   input wire logic serial_clock_i, // Serial clock pin
   input wire logic latch_strobe_i, // Latch strobe pin
   input wire logic outputs_disable_i, // Blanking pin, high forces off
   input wire logic gs_write_i, // Latch strobe carries a grayscale write
   input wire logic [CH*GSW-1:0] grayscale_level_i, // Grayscale levels, second latch
   input wire logic invisible_detect_enable_i, // Detection enable
   input wire logic [2:0] detect_current_select_i, // Detection current code
   input wire logic [1:0] result_latch_timing_i, // Latch timing code
   input wire logic [1:0] power_save_select_i, // Power save select low bits
   input wire logic leak_detect_enable_i, // Leak detection enable
   input wire ldp_sense_t sense_i, // Temperature and reference comparators
   input wire logic [CH-1:0] open_cmp_i, // Per-output open comparators
   input wire logic [CH-1:0] short_cmp_i, // Per-output short comparators
   input wire logic [CH-1:0] leak_cmp_i, // Per-output leak comparators
   output logic [CH-1:0] sink_output_o, // Staggered PWM output enables
   output logic [CH-1:0] detect_sink_o, // Detection current enables
   output logic [2:0] detect_current_o, // Detection current code
   output logic [CH-1:0] open_fault_flag_o, // Latched open results
   output logic [CH-1:0] short_fault_flag_o, // Latched short results
   output logic [CH-1:0] leak_fault_flag_o, // Latched leak results
   output ldp_status_t status_o, // Status readout flags
   output logic power_save_state_o // Power save active
);
   // Pin synchronisers: first stage only feeds second
   logic [2:0] pin_s1_q, pin_s2_q, pin_s3_q;
   logic [CH-1:0] open_s1_q, open_s2_q, short_s1_q, short_s2_q, leak_s1_q, leak_s2_q;
   ldp_sense_t sense_s1_q, sense_s2_q;
   logic blank_s1_q, blank_s2_q, blank_s3_q;

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         pin_s3_q <= '0;
         sense_s1_q <= '0;
         sense_s2_q <= '0;
         open_s1_q <= '0;
         open_s2_q <= '0;
         short_s1_q <= '0;
         short_s2_q <= '0;
         leak_s1_q <= '0;
         leak_s2_q <= '0;
         blank_s1_q <= 1'b1;
         blank_s2_q <= 1'b1;
         blank_s3_q <= 1'b1;
      end else begin
         pin_s1_q <= {grayscale_clock_i, serial_clock_i, latch_strobe_i};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         sense_s1_q <= sense_i;
         sense_s2_q <= sense_s1_q;
         open_s1_q <= open_cmp_i;
         open_s2_q <= open_s1_q;
         short_s1_q <= short_cmp_i;
         short_s2_q <= short_s1_q;
         leak_s1_q <= leak_cmp_i;
         leak_s2_q <= leak_s1_q;
         blank_s1_q <= outputs_disable_i;
         blank_s2_q <= blank_s1_q;
         blank_s3_q <= blank_s2_q;
      end
   end

   logic grayscale_clock_rise, sclk_rise, lat_rise, gs_lat_rise;
   assign grayscale_clock_rise = pin_s2_q[2] & ~pin_s3_q[2];
   assign sclk_rise = pin_s2_q[1] & ~pin_s3_q[1];
   assign lat_rise = pin_s2_q[0] & ~pin_s3_q[0];
   assign gs_lat_rise = lat_rise & gs_write_i;

   function automatic logic [GSW-1:0] lvl(input logic [CH*GSW-1:0] v, input int ch);
      lvl = v[ch*GSW +: GSW];
   endfunction

   function automatic logic [GSW-1:0] lat_count(input logic [1:0] code);
      case (code)
         2'h0: lat_count = GSW'(`LDP_LAT_CODE0);
         2'h1: lat_count = GSW'(`LDP_LAT_CODE1);
         2'h2: lat_count = GSW'(`LDP_LAT_CODE2);
         default: lat_count = GSW'(`LDP_LAT_CODE3);
      endcase
   endfunction

   // Grayscale counter; a period starts on the clock after wrap or latch
   logic [GSW-1:0] gs_cnt_q;
   logic period_start;
   assign period_start = grayscale_clock_rise && (gs_cnt_q == '0);

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || blank_s2_q || gs_lat_rise) begin
         gs_cnt_q <= '0;
      end else if (grayscale_clock_rise) begin
         gs_cnt_q <= gs_cnt_q + GSW'(1);
      end
   end

   // Power save
   ldp_ps_state_t ps_q;
   logic gs_all_zero, ps_enabled;
   assign gs_all_zero = (grayscale_level_i == '0);
   assign ps_enabled = (power_save_select_i != `LDP_PS_OFF);

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         ps_q <= LDP_RUN;
      end else begin
         case (ps_q)
            LDP_RUN: begin
               if (ps_enabled && power_save_select_i != `LDP_PS_ALT && gs_lat_rise && gs_all_zero) begin
                  ps_q <= LDP_SAVE;
               end
            end
            LDP_SAVE: begin
               if (sclk_rise && power_save_select_i == `LDP_PS_EXIT) begin
                  ps_q <= LDP_WAKE;
               end
            end
            LDP_WAKE: begin
               if (period_start) begin
                  ps_q <= LDP_RUN;
               end
            end
            default: ps_q <= LDP_RUN;
         endcase
      end
   end

   // Status flags
   logic warn_q, terr_q, ref_q, restart_wait_q;

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         warn_q <= 1'b0;
      end else if (sense_s2_q.warn_temp) begin
         warn_q <= 1'b1;
      end else if (gs_lat_rise) begin
         warn_q <= 1'b0;
      end
   end

   // error flag, set wins over clear
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         terr_q <= 1'b0;
      end else if (sense_s2_q.shut_temp) begin
         terr_q <= 1'b1;
      end else if (gs_lat_rise) begin
         terr_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         ref_q <= 1'b0;
      end else begin
         ref_q <= sense_s2_q.ref_short;
      end
   end

   // hold off until next period after thermal error, shutdown temperature or reference short
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         restart_wait_q <= 1'b0;
      end else if (terr_q || sense_s2_q.shut_temp || ref_q) begin
         restart_wait_q <= 1'b1;
      end else if (period_start && !blank_s2_q) begin
         restart_wait_q <= 1'b0;
      end
   end

   logic force_off;
   assign force_off = ref_q || terr_q || sense_s2_q.shut_temp || blank_s2_q ||
                      (restart_wait_q && !period_start) || (ps_q != LDP_RUN);

   // PWM compare: counter value 1 is the first clock of the period
   logic [CH-1:0] pwm_en, pwm_q;
   always_comb begin
      for (int c = 0; c < CH; c++) begin
         pwm_en[c] = !force_off && (gs_cnt_q != '0) && (gs_cnt_q <= lvl(grayscale_level_i, c));
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         pwm_q <= '0;
      end else begin
         pwm_q <= pwm_en;
      end
   end

   ldp_stagger #(
      .CH(CH),
      .STEP(STEP)
   ) u_stagger (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .en_i(pwm_q),
      .en_o(sink_output_o)
   );

   // Detection window
   logic det_q, det_on;
   assign det_on = invisible_detect_enable_i && (ps_q == LDP_RUN) && !force_off;
   logic det_end;
   assign det_end = grayscale_clock_rise && (gs_cnt_q + GSW'(1) == lat_count(result_latch_timing_i));

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         det_q <= 1'b0;
      end else if (!det_on || det_end) begin
         det_q <= 1'b0;
      end else if (period_start) begin
         det_q <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         detect_sink_o <= '0;
         detect_current_o <= '0;
      end else begin
         detect_sink_o <= {CH{det_q}};
         detect_current_o <= detect_current_select_i;
      end
   end

   // Result latches
   logic lat_event;
   assign lat_event = grayscale_clock_rise && (gs_cnt_q + GSW'(1) == lat_count(result_latch_timing_i));

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         open_fault_flag_o <= '0;
         short_fault_flag_o <= '0;
      end else if (lat_event && ps_q == LDP_RUN) begin
         if (det_q) begin
            open_fault_flag_o <= open_s2_q;
            short_fault_flag_o <= short_s2_q;
         end else begin
            open_fault_flag_o <= open_s2_q & pwm_q;
            short_fault_flag_o <= short_s2_q & pwm_q;
         end
      end
   end

   // Leak results latch at period end, on blanking or on a grayscale write; valid only for zero-level outputs
   logic [CH-1:0] gs_zero;
   always_comb begin
      for (int c = 0; c < CH; c++) begin
         gs_zero[c] = (lvl(grayscale_level_i, c) == '0);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         leak_fault_flag_o <= '0;
      end else if ((grayscale_clock_rise && gs_cnt_q == '1) || (blank_s2_q && !blank_s3_q) || gs_lat_rise) begin
         if (invisible_detect_enable_i || !leak_detect_enable_i) begin
            leak_fault_flag_o <= '0;
         end else begin
            leak_fault_flag_o <= leak_s2_q & gs_zero;
         end
      end
   end

   assign status_o = '{thermal_error_flag: terr_q, thermal_warning_flag: warn_q, ref_short_flag: ref_q};
   assign power_save_state_o = (ps_q != LDP_RUN);
endmodule

// ==== ldp_ctrl_monitor.sv ====
// Port checker for the diagnostic and protection controller.
// Assumes the bench holds the current code and grayscale write stable around events.
`timescale 1ns/1ps
module ldp_ctrl_monitor import ldp_pkg::*; #(
   parameter int CH = 16
) (
   input wire logic sys_clk_i, // Clock
   input wire logic sys_rst_i, // Reset
   input wire logic gs_write_i, // Grayscale write
   input wire logic invisible_detect_enable_i, // Detect enable
   input wire logic [2:0] detect_current_select_i, // Code in
   input wire ldp_sense_t sense_i, // Comparators
   input wire logic [CH-1:0] sink_output_o, // Outputs
   input wire logic [CH-1:0] detect_sink_o, // Detect enables
   input wire logic [2:0] detect_current_o, // Code out
   input wire ldp_status_t status_o, // Flags
   input wire logic power_save_state_o // Power save
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   det_equal_a: assert property ((detect_sink_o == '0) || (detect_sink_o == '1))
      else $error("detect enables differ");
   det_start_a: assert property ($rose(detect_sink_o[0]) |-> $past(invisible_detect_enable_i))
      else $error("detect started without enable");
   cur_code_a: assert property ($rose(detect_sink_o[0]) |-> detect_current_o == detect_current_select_i)
      else $error("detect current code wrong");
   det_psave_a: assert property (power_save_state_o && $past(power_save_state_o) && $past(power_save_state_o, 2)
      |-> detect_sink_o == '0)
      else $error("detect ran in power save");
   ref_off_a: assert property ($rose(status_o.ref_short_flag) |-> ##[1:20] sink_output_o == '0)
      else $error("reference short left outputs on");
   tef_off_a: assert property (status_o.thermal_error_flag && $past(status_o.thermal_error_flag, 20)
      |-> sink_output_o == '0)
      else $error("outputs on during thermal error");
   tef_clear_a: assert property ($fell(status_o.thermal_error_flag) |-> gs_write_i && !sense_i.shut_temp)
      else $error("thermal error cleared without write");
   warn_clear_a: assert property ($fell(status_o.thermal_warning_flag) |-> gs_write_i)
      else $error("warning cleared without write");
   warn_set_a: assert property (sense_i.warn_temp [*5] |-> status_o.thermal_warning_flag)
      else $error("warning flag not set");
   cover property ($rose(detect_sink_o[0]));
   cover property ($rose(status_o.thermal_error_flag));
   cover property ($rose(power_save_state_o));
endmodule
bind ldp_ctrl ldp_ctrl_monitor #(.CH(CH)) i_ldp_ctrl_monitor (.sys_clk_i, .sys_rst_i, .gs_write_i,
   .invisible_detect_enable_i, .detect_current_select_i, .sense_i, .sink_output_o, .detect_sink_o,
   .detect_current_o, .status_o, .power_save_state_o);

// ==== ldp_host_model.sv ====
// Host pin driver: grayscale clock, serial clock and latch strobe.
// Assumes one bench process calls its tasks at falling system clock edges.
`timescale 1ns/1ps
module ldp_host_model #(
   parameter int HALF = 3
) (
   input wire logic sys_clk_i, // System clock
   output logic grayscale_clock_o, // Grayscale clock pin
   output logic serial_clock_o, // Serial clock pin
   output logic latch_strobe_o // Latch strobe pin
);
   initial begin
      grayscale_clock_o = 1'b0;
      serial_clock_o = 1'b0;
      latch_strobe_o = 1'b0;
   end
   // phases long enough
   // Clock stands low between bursts; each phase spans HALF cycles for the synchronisers
   task automatic gs_clocks(input int n);
      for (int i = 0; i < n; i++) begin
         repeat (HALF) @(negedge sys_clk_i);
         grayscale_clock_o = 1'b1;
         repeat (HALF) @(negedge sys_clk_i);
         grayscale_clock_o = 1'b0;
      end
   endtask
   task automatic strobe();
      latch_strobe_o = 1'b1;
      repeat (HALF) @(negedge sys_clk_i);
      latch_strobe_o = 1'b0;
      repeat (HALF) @(negedge sys_clk_i);
   endtask
   task automatic sclk();
      serial_clock_o = 1'b1;
      repeat (HALF) @(negedge sys_clk_i);
      serial_clock_o = 1'b0;
      repeat (HALF) @(negedge sys_clk_i);
   endtask
endmodule

// ==== test_ldp_ctrl.sv ====
// Self-checking bench for the diagnostic and protection controller.
// Assumes the host model makes pin edges and the bound checker watches the ports.
`timescale 1ns/1ps
module test_ldp_ctrl import ldp_pkg::*;;
   logic sys_clk_i;
   logic sys_rst_i;
   logic grayscale_clock, sclk, lat;
   logic blank, gs_wr, invisible_detect_enable, leak_en;
   logic [255:0] gs;
   logic [2:0] cur;
   logic [1:0] result_latch_timing, pss;
   ldp_sense_t sense;
   logic [15:0] ocmp, scmp, lcmp;
   logic [15:0] sink, det, oflag, sflag, lflag;
   logic [2:0] dcur;
   ldp_status_t st;
   logic ps;
   int err_count = 0, n_tests = 0, cyc = 0;
   int cnt[4];
   always #5 sys_clk_i = ~sys_clk_i;
   ldp_host_model #(.HALF(3)) i_ldp_host_model (.sys_clk_i(sys_clk_i), .grayscale_clock_o(grayscale_clock),
      .serial_clock_o(sclk), .latch_strobe_o(lat));
   ldp_ctrl #(.CH(16), .GSW(16), .STEP(4)) i_ldp_ctrl (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
      .grayscale_clock_i(grayscale_clock), .serial_clock_i(sclk), .latch_strobe_i(lat), .outputs_disable_i(blank),
      .gs_write_i(gs_wr), .grayscale_level_i(gs), .invisible_detect_enable_i(invisible_detect_enable),
      .detect_current_select_i(cur), .result_latch_timing_i(result_latch_timing), .power_save_select_i(pss),
      .leak_detect_enable_i(leak_en), .sense_i(sense), .open_cmp_i(ocmp), .short_cmp_i(scmp),
      .leak_cmp_i(lcmp), .sink_output_o(sink), .detect_sink_o(det), .detect_current_o(dcur),
      .open_fault_flag_o(oflag), .short_fault_flag_o(sflag), .leak_fault_flag_o(lflag),
      .status_o(st), .power_save_state_o(ps));
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask
   task automatic blank_pulse();
      blank = 1'b1;
      wt(4);
      blank = 1'b0;
      wt(4);
   endtask
   // Grayscale write also restarts the display period
   task automatic gs_write(input logic [255:0] v);
      gs = v;
      gs_wr = 1'b1;
      i_ldp_host_model.strobe();
      gs_wr = 1'b0;
      wt(4);
   endtask
   task automatic t_stagger();
      logic [255:0] v;
      int n;
      v = {16{16'h0002}};
      v[31:16] = 16'h0000;
      gs_write(v);
      i_ldp_host_model.gs_clocks(1);
      for (n = 0; n < 20 && sink === 16'h0000; n++) wt(1);
      chk(sink, 16'h8181);
      wt(4);
      chk(sink, 16'hc3c1);
      wt(4);
      chk(sink, 16'he7e5);
      wt(4);
      chk(sink, 16'hfffd);
      i_ldp_host_model.gs_clocks(4);
      wt(20);
      chk(sink, 16'h0000);
   endtask
   task automatic t_detect();
      int n;
      gs_write('0);
      i_ldp_host_model.gs_clocks(4);
      wt(10);
      chk(oflag, 16'h0000);
      chk(sflag, 16'h0000);
      invisible_detect_enable = 1'b1;
      for (int c = 0; c < 4; c++) begin
         result_latch_timing = c[1:0];
         cur = {1'b1, c[1:0]};
         blank_pulse();
         for (n = 0; n < 200 && (n == 0 || det !== 16'h0000); n++) begin
            i_ldp_host_model.gs_clocks(1);
            wt(8);
            if (n == 0) chk(det, 16'hffff);
         end
         cnt[c] = n;
      end
      chk(oflag, 16'h00a5);
      chk(sflag, 16'h5a00);
      chk({13'h0, dcur}, 16'h0007);
      chk(16'(cnt[1] - cnt[0]), 16'h001f);
      chk(16'(cnt[2] - cnt[1]), 16'h0020);
      chk(16'(cnt[3] - cnt[2]), 16'h0040);
      blank_pulse();
      chk(lflag, 16'h0000);
      invisible_detect_enable = 1'b0;
      blank_pulse();
      chk(lflag, 16'hffff);
      leak_en = 1'b0;
      blank_pulse();
      chk(lflag, 16'h0000);
      leak_en = 1'b1;
   endtask
   task automatic t_psave();
      for (int s = 0; s < 4; s++) begin
         pss = s[1:0];
         gs_write('0);
         chk({15'h0, ps}, {15'h0, s == 1 || s == 2});
         if (ps === 1'b1) begin
            invisible_detect_enable = 1'b1;
            i_ldp_host_model.gs_clocks(3);
            wt(6);
            chk(det, 16'h0000);
            invisible_detect_enable = 1'b0;
            if (s == 2) begin
               i_ldp_host_model.sclk();
               chk({15'h0, ps}, 16'h0001);
            end
            pss = 2'h1;
            i_ldp_host_model.sclk();
            gs_write({16{16'h0010}});
            wt(20);
            chk(sink, 16'h0000);
            i_ldp_host_model.gs_clocks(1);
            wt(20);
            chk(sink, 16'hffff);
            chk({15'h0, ps}, 16'h0000);
         end
      end
   endtask
   task automatic t_thermal();
      gs_write({16{16'h0100}});
      i_ldp_host_model.gs_clocks(1);
      wt(20);
      sense.warn_temp = 1'b1;
      wt(8);
      chk({13'h0, st}, 16'h0002);
      chk(sink, 16'hffff);
      sense.warn_temp = 1'b0;
      wt(8);
      chk({13'h0, st}, 16'h0002);
      gs_write({16{16'h0100}});
      chk({13'h0, st}, 16'h0000);
      i_ldp_host_model.gs_clocks(1);
      wt(20);
      sense.shut_temp = 1'b1;
      wt(25);
      chk({13'h0, st}, 16'h0004);
      chk(sink, 16'h0000);
      sense.shut_temp = 1'b0;
      wt(8);
      i_ldp_host_model.gs_clocks(1);
      wt(20);
      chk({13'h0, st}, 16'h0004);
      chk(sink, 16'h0000);
      gs_write({16{16'h0100}});
      chk({13'h0, st}, 16'h0000);
      chk(sink, 16'h0000);
      i_ldp_host_model.gs_clocks(1);
      wt(20);
      chk(sink, 16'hffff);
      sense.ref_short = 1'b1;
      wt(25);
      chk({13'h0, st}, 16'h0001);
      chk(sink, 16'h0000);
      sense.ref_short = 1'b0;
   endtask
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 40000) begin
         err_count++;
         end_of_test();
      end
   end
   initial begin
      sys_clk_i = 1'b0;
      sys_rst_i = 1'b1;
      blank = 1'b1;
      gs_wr = 1'b0;
      invisible_detect_enable = 1'b0;
      leak_en = 1'b1;
      gs = '0;
      cur = 3'h5;
      result_latch_timing = 2'h0;
      pss = 2'h0;
      sense = '0;
      ocmp = 16'h00a5;
      scmp = 16'h5a00;
      lcmp = 16'hffff;
      wt(3);
      sys_rst_i = 1'b0;
      blank = 1'b0;
      wt(4);
      t_stagger();
      t_detect();
      t_psave();
      t_thermal();
      end_of_test();
   end
endmodule
